//--- include/tmrh_regs.svh
// register map, field positions, reset values and mode codes of the compare timer
`ifndef TMRH_REGS_SVH
`define TMRH_REGS_SVH

`define TMRH_PRI0_ADDR   16'hff18
`define TMRH_SEC0_ADDR   16'hff19
`define TMRH_PRI1_ADDR   16'hff1a
`define TMRH_SEC1_ADDR   16'hff1b
`define TMRH_MODE0_ADDR  16'hff69
`define TMRH_MODE1_ADDR  16'hff6c
`define TMRH_CNT0_ADDR   16'hff1c
`define TMRH_CNT1_ADDR   16'hff1d

`define TMRH_REG_RESET   8'h00

`define TMRH_RUN_POS     7
`define TMRH_CKS_MSB     6
`define TMRH_CKS_LSB     4
`define TMRH_MODE_MSB    3
`define TMRH_MODE_LSB    2
`define TMRH_LEV_POS     1
`define TMRH_EN_POS      0

`define TMRH_MD_INTERVAL 2'h0
`define TMRH_MD_CARRIER  2'h1
`define TMRH_MD_PWM      2'h2

`define TMRH_CKS_EXT     3'h5

`endif

//--- include/tmrh_pkg.sv
// types of the compare timer
package tmrh_pkg;

    typedef struct packed {
        logic [1:0][7:0] cnt;
        logic [1:0][7:0] pri;
        logic [1:0][7:0] sec;
        logic [1:0][7:0] act;
        logic [1:0][7:0] mode;
        logic [1:0]      tout;
        logic [1:0]      pin;
        logic [1:0]      irq;
        logic [1:0]      s1;
        logic [1:0]      s2;
        logic [1:0]      s3;
        logic [11:0]     presc;
        logic [7:0]      rdata;
    } tmrh_state_t;

endpackage : tmrh_pkg

//--- logic/tmrh_timer.sv
// two-channel eight-bit compare timer with cpu register port
`timescale 1ns/1ns
`include "tmrh_regs.svh"

module tmrh_timer (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic        bit_wr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    input  wire logic        companion_timer_out,
    input  wire logic        aux_clock_in,
    output logic      [1:0]  match_interrupt,
    output logic      [1:0]  timer_output_pin
);

    localparam logic [1:0][15:0] PRI_A  = {`TMRH_PRI1_ADDR, `TMRH_PRI0_ADDR};
    localparam logic [1:0][15:0] SEC_A  = {`TMRH_SEC1_ADDR, `TMRH_SEC0_ADDR};
    localparam logic [1:0][15:0] MODE_A = {`TMRH_MODE1_ADDR, `TMRH_MODE0_ADDR};
    localparam logic [1:0][15:0] CNT_A  = {`TMRH_CNT1_ADDR, `TMRH_CNT0_ADDR};

    tmrh_pkg::tmrh_state_t q;
    tmrh_pkg::tmrh_state_t n;

    logic [1:0] tick;
    logic [1:0] run;
    logic [1:0] hit_pri;
    logic [1:0] hit_sec;
    logic [1:0] sec_wr;

    // tick of a power-of-two divider taken from the shared prescaler
    function automatic logic div_tick(input logic [11:0] presc, input logic [3:0] k);
        logic [11:0] mask;
        mask = (12'h001 << k) - 12'h001;
        div_tick = &(presc | ~mask);
    endfunction : div_tick

    always_comb begin
        logic [2:0] cks;
        logic [1:0] md;
        logic       lev;
        logic       clr;
        cks = 3'h0;
        md  = 2'h0;
        lev = 1'b0;
        clr = 1'b0;
        n = q;
        n.irq = 2'h0;
        n.s1 = {aux_clock_in, companion_timer_out};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.presc = q.presc + 12'h001;
        tick = 2'h0;
        run = 2'h0;
        hit_pri = 2'h0;
        hit_sec = 2'h0;
        sec_wr = 2'h0;
        for (int ch = 0; ch < 2; ch++) begin
            run[ch] = q.mode[ch][`TMRH_RUN_POS];
            cks = q.mode[ch][`TMRH_CKS_MSB:`TMRH_CKS_LSB];
            md = q.mode[ch][`TMRH_MODE_MSB:`TMRH_MODE_LSB];
            lev = q.mode[ch][`TMRH_LEV_POS];
            // channel 1 divides more coarsely on codes 1, 2 and 4; code 5 is an external edge on both
            case (cks)
                3'h0: tick[ch] = 1'b1;
                3'h1: tick[ch] = div_tick(q.presc, (ch == 0) ? 4'h1 : 4'h2);
                3'h2: tick[ch] = div_tick(q.presc, (ch == 0) ? 4'h2 : 4'h4);
                3'h3: tick[ch] = div_tick(q.presc, 4'h6);
                3'h4: tick[ch] = div_tick(q.presc, (ch == 0) ? 4'ha : 4'hc);
                `TMRH_CKS_EXT: tick[ch] = q.s2[ch] & ~q.s3[ch];
                default: tick[ch] = 1'b0;
            endcase
            sec_wr[ch] = wr_en && !bit_wr && (addr == SEC_A[ch]);
            hit_pri[ch] = run[ch] && tick[ch] && (q.cnt[ch] == q.pri[ch]);
            hit_sec[ch] = run[ch] && tick[ch] && (q.cnt[ch] == q.act[ch]);
            // carrier mode exists on channel 1 only
            clr = (ch == 1 && md == `TMRH_MD_CARRIER) ? hit_sec[ch] : hit_pri[ch];
            if (!run[ch]) begin
                n.cnt[ch] = 8'h00;
            end else if (tick[ch]) begin
                n.cnt[ch] = clr ? 8'h00 : q.cnt[ch] + 8'h01;
            end
            n.irq[ch] = clr;
            // interval mode never looks at the secondary compare
            if (hit_sec[ch] && md != `TMRH_MD_INTERVAL && !sec_wr[ch]) begin
                n.act[ch] = q.sec[ch];
            end
            if (!run[ch]) begin
                n.tout[ch] = lev;
            end else begin
                case (md)
                    `TMRH_MD_INTERVAL: begin
                        if (hit_pri[ch]) begin
                            n.tout[ch] = ~q.tout[ch];
                        end
                    end
                    `TMRH_MD_PWM: begin
                        if (hit_sec[ch]) begin
                            n.tout[ch] = lev;
                        end else if (hit_pri[ch]) begin
                            n.tout[ch] = ~lev;
                        end
                    end
                    `TMRH_MD_CARRIER: begin
                        if (ch == 1 && hit_sec[ch]) begin
                            n.tout[ch] = ~q.tout[ch];
                        end
                    end
                    default: n.tout[ch] = q.tout[ch];
                endcase
            end
            n.pin[ch] = q.mode[ch][`TMRH_EN_POS] & n.tout[ch];
            if (wr_en && !bit_wr && addr == PRI_A[ch]) begin
                n.pri[ch] = wr_data;
            end
            if (sec_wr[ch]) begin
                n.sec[ch] = wr_data;
                // stopped: the active stage follows at once, ready for restart
                if (!run[ch]) begin
                    n.act[ch] = wr_data;
                end
            end
            if (wr_en && addr == MODE_A[ch]) begin
                if (bit_wr) begin
                    n.mode[ch][bit_sel] = wr_data[0];
                end else begin
                    n.mode[ch] = wr_data;
                end
            end
        end
        if (rd_en) begin
            n.rdata = 8'h00;
            for (int ch = 0; ch < 2; ch++) begin
                if (addr == PRI_A[ch]) begin
                    n.rdata = q.pri[ch];
                end
                if (addr == SEC_A[ch]) begin
                    n.rdata = q.sec[ch];
                end
                if (addr == MODE_A[ch]) begin
                    n.rdata = q.mode[ch];
                end
                if (addr == CNT_A[ch]) begin
                    n.rdata = q.cnt[ch];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rd_data = q.rdata;
    assign match_interrupt = q.irq;
    assign timer_output_pin = q.pin;

    property p_stop_zero;
        @(posedge clk) disable iff (!arst_n)
        !run[0] |=> (q.cnt[0] == 8'h00);
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("counter not held at zero");

    property p_pri_match;
        @(posedge clk) disable iff (!arst_n)
        hit_pri[0] |=> (match_interrupt[0] && q.cnt[0] == 8'h00);
    endproperty
    a_pri_match: assert property (p_pri_match) else $error("primary match missed");

    property p_incr;
        @(posedge clk) disable iff (!arst_n)
        (run[0] && tick[0] && !hit_pri[0]) |=> (q.cnt[0] == $past(q.cnt[0]) + 8'h01);
    endproperty
    a_incr: assert property (p_incr) else $error("counter did not step");

    property p_hold;
        @(posedge clk) disable iff (!arst_n)
        (run[0] && !tick[0]) |=> $stable(q.cnt[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without tick");

    property p_carrier;
        @(posedge clk) disable iff (!arst_n)
        (hit_sec[1] && q.mode[1][3:2] == `TMRH_MD_CARRIER)
            |=> (match_interrupt[1] && q.cnt[1] == 8'h00);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier match missed");

    property p_transfer;
        @(posedge clk) disable iff (!arst_n)
        (hit_sec[0] && q.mode[0][3:2] == `TMRH_MD_PWM && !sec_wr[0])
            |=> (q.act[0] == $past(q.sec[0]));
    endproperty
    a_transfer: assert property (p_transfer) else $error("secondary not transferred");

    property p_collide;
        @(posedge clk) disable iff (!arst_n)
        (hit_sec[0] && sec_wr[0]) |=> $stable(q.act[0]);
    endproperty
    a_collide: assert property (p_collide) else $error("transfer not skipped");

    property p_run_write;
        @(posedge clk) disable iff (!arst_n)
        (sec_wr[1] && run[1]) |=> (q.sec[1] == $past(wr_data));
    endproperty
    a_run_write: assert property (p_run_write) else $error("running write lost");

    property p_toggle;
        @(posedge clk) disable iff (!arst_n)
        (hit_pri[0] && q.mode[0][3:2] == `TMRH_MD_INTERVAL)
            |=> (q.tout[0] != $past(q.tout[0]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("output not inverted");

    property p_pin_off;
        @(posedge clk) disable iff (!arst_n)
        !q.mode[0][`TMRH_EN_POS] ##1 !q.mode[0][`TMRH_EN_POS] |-> !timer_output_pin[0];
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin driven");

    property p_div2;
        @(posedge clk) disable iff (!arst_n)
        (q.mode[0][6:4] == 3'h1 && tick[0]) |=> !tick[0] ##1 (tick[0] || q.mode[0][6:4] != 3'h1);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two wrong");

    property p_byte_wr;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && !bit_wr && addr == `TMRH_MODE0_ADDR) |=> (q.mode[0] == $past(wr_data));
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("mode write lost");

endmodule : tmrh_timer

//--- verif/tmrh_timer_test.sv
// self-checking bench of the two-channel compare timer
`timescale 1ns/1ns
`include "tmrh_regs.svh"

module tmrh_timer_test;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        wr_en = 1'b0;
    logic        bit_wr = 1'b0;
    logic [2:0]  bit_sel = 3'h0;
    logic [7:0]  wr_data = 8'h00;
    logic        rd_en = 1'b0;
    logic [7:0]  rd_data;
    logic        companion_timer_out = 1'b0;
    logic        aux_clock_in = 1'b0;
    logic [1:0]  match_interrupt;
    logic [1:0]  timer_output_pin;
    logic [2:0]  edge_cnt = 3'h0;
    logic        rd_seen = 1'b0;
    logic [7:0]  exp_q[$];
    logic [7:0]  v;
    int          n_fail = 0;
    int          n_compared = 0;
    int          nv;
    // last entry is the companion edge rate made below
    int          div[6] = '{1, 2, 4, 64, 1024, 8};
    logic [15:0] map[9] = '{`TMRH_PRI0_ADDR, `TMRH_SEC0_ADDR, `TMRH_PRI1_ADDR,
                            `TMRH_SEC1_ADDR, `TMRH_MODE0_ADDR, `TMRH_MODE1_ADDR,
                            `TMRH_CNT0_ADDR, `TMRH_CNT1_ADDR, 16'hff00};

    tmrh_timer DUT (
        .clk                 (clk),
        .arst_n              (arst_n),
        .addr                (addr),
        .wr_en               (wr_en),
        .bit_wr              (bit_wr),
        .bit_sel             (bit_sel),
        .wr_data             (wr_data),
        .rd_en               (rd_en),
        .rd_data             (rd_data),
        .companion_timer_out (companion_timer_out),
        .aux_clock_in        (aux_clock_in),
        .match_interrupt     (match_interrupt),
        .timer_output_pin    (timer_output_pin)
    );

    always #2 clk = ~clk;

    // companion and aux run free before any select, rising edge every 8 cycles
    always @(posedge clk) begin
        edge_cnt            <= edge_cnt + 3'h1;
        companion_timer_out <= edge_cnt[2];
        aux_clock_in        <= ~edge_cnt[2];
        rd_seen             <= rd_en;
    end

    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rd_data, exp_q.pop_front());
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // one access per two cycles so no strobe is assigned twice in a time step
    task acc(input logic [15:0] a, input logic [7:0] d, input logic [2:0] s,
             input logic w, input logic b, input logic r);
        addr    <= a;
        wr_data <= d;
        bit_sel <= s;
        wr_en   <= w;
        bit_wr  <= b;
        rd_en   <= r;
        @(posedge clk);
        wr_en   <= 1'b0;
        bit_wr  <= 1'b0;
        rd_en   <= 1'b0;
        @(posedge clk);
    endtask : acc

    task wr(input logic [15:0] a, input logic [7:0] d);
        acc(a, d, 3'h0, 1'b1, 1'b0, 1'b0);
    endtask : wr

    task bwr(input logic [15:0] a, input logic [2:0] s, input logic b);
        acc(a, {7'h00, b}, s, 1'b1, 1'b1, 1'b0);
    endtask : bwr

    task rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, 8'h00, 3'h0, 1'b0, 1'b0, 1'b1);
    endtask : rd

    task wait_irq(input int ch, inout int n);
        while (match_interrupt[ch] !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9000) begin
            n_fail++;
            print_verdict;
        end
    endtask : wait_irq

    // cycles between two clearing matches, output must flip on each
    task measure(input int ch, input int exp);
        int   n;
        logic p0;
        n = 0;
        wait_irq(ch, n);
        p0 = timer_output_pin[ch];
        n = 1;
        @(negedge clk);
        wait_irq(ch, n);
        check(n, exp);
        check(timer_output_pin[ch], !p0);
        @(posedge clk);
    endtask : measure

    // pwm on channel 0: cycles the pin stays high after a primary match
    task hi_time(output int n);
        n = 0;
        wait_irq(0, n);
        n = 0;
        while (timer_output_pin[0] === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : hi_time

    initial begin
        void'($urandom(32'h2de4));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (map[i]) rd(map[i], 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(map[i], v);
            bwr(map[i], 3'h0, ~v[0]);
            rd(map[i], v);
        end
        v = 8'($urandom) & 8'h7f;
        wr(`TMRH_MODE1_ADDR, v);
        rd(`TMRH_MODE1_ADDR, v);
        wr(`TMRH_MODE0_ADDR, 8'h00);
        bwr(`TMRH_MODE0_ADDR, 3'h1, 1'b1);
        bwr(`TMRH_MODE0_ADDR, 3'h0, 1'b1);
        rd(`TMRH_MODE0_ADDR, 8'h03);
        check(timer_output_pin[0], 1'b1);
        bwr(`TMRH_MODE0_ADDR, 3'h0, 1'b0);
        // pin is launched on the edge the task returns at
        @(negedge clk);
        check(timer_output_pin[0], 1'b0);
        for (int c = 0; c < 6; c++) begin
            nv = 1 + $urandom % 3;
            // stop by the run bit alone, other bits change only while stopped
            bwr(`TMRH_MODE0_ADDR, 3'h7, 1'b0);
            wr(`TMRH_PRI0_ADDR, 8'(nv));
            wr(`TMRH_MODE0_ADDR, {1'b1, 3'(c), 4'h1});
            measure(0, (nv + 1) * div[c]);
        end
        bwr(`TMRH_MODE0_ADDR, 3'h7, 1'b0);
        rd(`TMRH_CNT0_ADDR, 8'h00);
        rd(`TMRH_MODE0_ADDR, 8'h51);
        wr(`TMRH_MODE0_ADDR, 8'h09);
        wr(`TMRH_SEC0_ADDR, 8'h03);
        wr(`TMRH_PRI0_ADDR, 8'h0e);
        wr(`TMRH_MODE0_ADDR, 8'h89);
        hi_time(nv);
        check(nv, 4);
        wr(`TMRH_SEC0_ADDR, 8'h06);
        hi_time(nv);
        check(nv, 4);
        hi_time(nv);
        check(nv, 7);
        // pending value, then a write landing on the secondary match itself
        wr(`TMRH_SEC0_ADDR, 8'h02);
        nv = 0;
        wait_irq(0, nv);
        repeat (6) @(posedge clk);
        wr(`TMRH_SEC0_ADDR, 8'h04);
        hi_time(nv);
        check(nv, 7);
        hi_time(nv);
        check(nv, 5);
        bwr(`TMRH_MODE0_ADDR, 3'h7, 1'b0);
        wr(`TMRH_MODE1_ADDR, 8'h00);
        nv = 2 + $urandom % 4;
        wr(`TMRH_SEC1_ADDR, 8'(nv));
        wr(`TMRH_MODE1_ADDR, 8'hd5);
        measure(1, (nv + 1) * 8);
        nv = 2 + $urandom % 4;
        wr(`TMRH_SEC1_ADDR, 8'(nv));
        measure(1, (nv + 1) * 8);
        // reset again while channel 1 runs
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(`TMRH_MODE1_ADDR, 8'h00);
        rd(`TMRH_SEC1_ADDR, 8'h00);
        rd(`TMRH_CNT1_ADDR, 8'h00);
        print_verdict;
    end
endmodule : tmrh_timer_test
